// [logic/trwu_consts.svh]
`ifndef TRWU_CONSTS_SVH
`define TRWU_CONSTS_SVH
// opcode layout
`define TRWU_OP_W        16
`define TRWU_OP_HI_ZERO  12'h000
`define TRWU_OP_RD_SEL   2'h2
`define TRWU_OP_WR_SEL   2'h3
// pointer and data widths
`define TRWU_PTR_W       21
`define TRWU_DATA_W      8
// holding register bank: index bits taken from pointer low bits
`define TRWU_HOLD_IDX_W  6
`define TRWU_HOLD_DEPTH  64
// reset values
`define TRWU_PTR_RST     21'h000000
`define TRWU_LAT_RST     8'h00
// phase numbering within an instruction cycle
`define TRWU_PH_Q1       2'h0
`define TRWU_PH_Q2       2'h1
`define TRWU_PH_Q3       2'h2
`define TRWU_PH_Q4       2'h3
`endif

// [logic/trwu_hold_mem.sv]
`timescale 1ns/10ps
`default_nettype none
`include "trwu_consts.svh"
module trwu_hold_mem
(
  input  wire logic                          i_clk,
  input  wire logic                          i_we,
  input  wire logic [`TRWU_HOLD_IDX_W-1:0]   i_waddr,
  input  wire logic [`TRWU_DATA_W-1:0]       i_wdata,
  input  wire logic [`TRWU_HOLD_IDX_W-1:0]   i_raddr,
  output logic      [`TRWU_DATA_W-1:0]       o_rdata
);
  logic [`TRWU_DATA_W-1:0] mem_q [0:`TRWU_HOLD_DEPTH-1];

  // staging bytes only; array programming happens elsewhere
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem_q[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_q[i_raddr];
  end
endmodule : trwu_hold_mem
`default_nettype wire

// [logic/trwu_pkg.sv]
`include "trwu_consts.svh"
package trwu_pkg;
  typedef enum logic [1:0] {
    TRWU_MODE_NONE,
    TRWU_MODE_POST_INC,
    TRWU_MODE_POST_DEC,
    TRWU_MODE_PRE_INC
  } trwu_mode_type;

  typedef enum logic [1:0] {
    TRWU_ST_IDLE,
    TRWU_ST_DECODE,
    TRWU_ST_EXEC
  } trwu_state_type;
endpackage : trwu_pkg

// [logic/trwu_unit.sv]
`timescale 1ns/10ps
`default_nettype none
`include "trwu_consts.svh"
module trwu_unit
(
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  input  wire logic [1:0]                  i_phase,
  input  wire logic                        i_op_valid,
  input  wire logic [`TRWU_OP_W-1:0]       i_opcode,
  input  wire logic                        i_ptr_load,
  input  wire logic [`TRWU_PTR_W-1:0]      i_ptr_data,
  input  wire logic                        i_lat_load,
  input  wire logic [`TRWU_DATA_W-1:0]     i_lat_data,
  input  wire logic [15:0]                 i_pmem_word,
  input  wire logic [`TRWU_HOLD_IDX_W-1:0] i_hold_raddr,
  output logic      [`TRWU_DATA_W-1:0]     o_hold_rdata,
  output logic      [`TRWU_PTR_W-1:0]      o_pmem_addr,
  output logic                             o_pmem_rd,
  output logic      [`TRWU_PTR_W-1:0]      o_table_byte_pointer,
  output logic      [`TRWU_DATA_W-1:0]     o_table_data_latch,
  output logic                             o_busy,
  output logic                             o_hold_we,
  output logic                             o_table_op
);
  typedef struct packed {
    trwu_pkg::trwu_state_type  st;
    logic                      is_wr;
    trwu_pkg::trwu_mode_type   mode;
    logic [`TRWU_PTR_W-1:0]    ptr;
    logic [`TRWU_DATA_W-1:0]   lat;
    logic [`TRWU_DATA_W-1:0]   fetch;
  } trwu_state_s_type;

  trwu_state_s_type s_q;
  trwu_state_s_type s_d;

  logic is_rd_op;
  logic is_wr_op;
  logic hold_we;
  logic [`TRWU_PTR_W-1:0] acc_ptr;
  logic [`TRWU_PTR_W-1:0] one_ptr;

  ////////////////////////////////////////////////////////////////
  // decode
  assign is_rd_op = i_op_valid && (i_phase == `TRWU_PH_Q1)
                    && (i_opcode[15:4] == `TRWU_OP_HI_ZERO)
                    && (i_opcode[3:2] == `TRWU_OP_RD_SEL);
  assign is_wr_op = i_op_valid && (i_phase == `TRWU_PH_Q1)
                    && (i_opcode[15:4] == `TRWU_OP_HI_ZERO)
                    && (i_opcode[3:2] == `TRWU_OP_WR_SEL);
  // constant one at pointer width, so wrap stays inside 21 bits
  assign one_ptr = {{(`TRWU_PTR_W-1){1'b0}}, 1'b1};
  // access address: pre-increment applies before the access
  assign acc_ptr = (s_q.mode == trwu_pkg::TRWU_MODE_PRE_INC) ? s_q.ptr + one_ptr : s_q.ptr;

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_d = s_q;
    unique case (s_q.st)
      trwu_pkg::TRWU_ST_IDLE,
      trwu_pkg::TRWU_ST_DECODE:
      begin
        if (s_q.st == trwu_pkg::TRWU_ST_DECODE && i_phase == `TRWU_PH_Q4)
        begin
          s_d.st = trwu_pkg::TRWU_ST_EXEC;
        end
        else if (s_q.st == trwu_pkg::TRWU_ST_IDLE && (is_rd_op || is_wr_op))
        begin
          s_d.st    = trwu_pkg::TRWU_ST_DECODE;
          s_d.is_wr = is_wr_op;
          s_d.mode  = trwu_pkg::trwu_mode_type'(i_opcode[1:0]);
        end
      end
      trwu_pkg::TRWU_ST_EXEC:
      begin
        if (i_phase == `TRWU_PH_Q2 && !s_q.is_wr)
        begin
          // byte pick by access address bit zero
          s_d.fetch = acc_ptr[0] ? i_pmem_word[15:8] : i_pmem_word[7:0];
        end
        if (i_phase == `TRWU_PH_Q4)
        begin
          if (!s_q.is_wr)
          begin
            s_d.lat = s_q.fetch;
          end
          unique case (s_q.mode)
            trwu_pkg::TRWU_MODE_NONE:     s_d.ptr = s_q.ptr;
            trwu_pkg::TRWU_MODE_POST_INC: s_d.ptr = s_q.ptr + one_ptr;
            trwu_pkg::TRWU_MODE_POST_DEC: s_d.ptr = s_q.ptr - one_ptr;
            trwu_pkg::TRWU_MODE_PRE_INC:  s_d.ptr = acc_ptr;
          endcase
          s_d.st = trwu_pkg::TRWU_ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = trwu_pkg::TRWU_ST_IDLE;
      end
    endcase
    // core-side loads when no table instruction is running
    if (s_q.st == trwu_pkg::TRWU_ST_IDLE)
    begin
      if (i_ptr_load)
      begin
        s_d.ptr = i_ptr_data;
      end
      if (i_lat_load)
      begin
        s_d.lat = i_lat_data;
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s_q.st    <= trwu_pkg::TRWU_ST_IDLE;
      s_q.is_wr <= 1'b0;
      s_q.mode  <= trwu_pkg::TRWU_MODE_NONE;
      s_q.ptr   <= `TRWU_PTR_RST;
      s_q.lat   <= `TRWU_LAT_RST;
      s_q.fetch <= `TRWU_LAT_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // holding register staging
  assign hold_we = (s_q.st == trwu_pkg::TRWU_ST_EXEC) && s_q.is_wr && (i_phase == `TRWU_PH_Q4);

  trwu_hold_mem u_hold
  (
    .i_clk   (i_clk),
    .i_we    (hold_we),
    .i_waddr (acc_ptr[`TRWU_HOLD_IDX_W-1:0]),
    .i_wdata (s_q.lat),
    .i_raddr (i_hold_raddr),
    .o_rdata (o_hold_rdata)
  );

  // outputs
  assign o_pmem_addr          = acc_ptr;
  assign o_pmem_rd            = (s_q.st == trwu_pkg::TRWU_ST_EXEC) && !s_q.is_wr && (i_phase == `TRWU_PH_Q2);
  assign o_table_byte_pointer = s_q.ptr;
  assign o_table_data_latch   = s_q.lat;
  assign o_busy               = (s_q.st != trwu_pkg::TRWU_ST_IDLE);
  assign o_hold_we            = hold_we;
  assign o_table_op           = is_rd_op || is_wr_op;

  ////////////////////////////////////////////////////////////////
  // assertions
  a_rd_latch_update: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_pmem_rd ##2 (s_q.st == trwu_pkg::TRWU_ST_EXEC && i_phase == `TRWU_PH_Q4)) |=> (s_q.lat == $past(s_q.fetch)))
    else $error("latch not loaded from fetched byte");
  a_post_inc_ptr: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_q.st == trwu_pkg::TRWU_ST_EXEC && i_phase == `TRWU_PH_Q4 && s_q.mode == trwu_pkg::TRWU_MODE_POST_INC)
    |=> (s_q.ptr == $past(s_q.ptr) + one_ptr))
    else $error("post increment wrong");
  a_post_dec_ptr: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_q.st == trwu_pkg::TRWU_ST_EXEC && i_phase == `TRWU_PH_Q4 && s_q.mode == trwu_pkg::TRWU_MODE_POST_DEC)
    |=> (s_q.ptr == $past(s_q.ptr) - one_ptr))
    else $error("post decrement wrong");
  a_pre_inc_addr: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_pmem_rd && s_q.mode == trwu_pkg::TRWU_MODE_PRE_INC) |-> (o_pmem_addr == s_q.ptr + one_ptr))
    else $error("pre increment address wrong");
  a_rd_fetch_phase: assert property (@(posedge i_clk) disable iff (i_reset)
    o_pmem_rd |-> (i_phase == `TRWU_PH_Q2 && !s_q.is_wr))
    else $error("fetch outside phase two");
  a_op_two_cycles: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_q.st == trwu_pkg::TRWU_ST_DECODE && i_phase == `TRWU_PH_Q4) |=> (s_q.st == trwu_pkg::TRWU_ST_EXEC) [*4] ##1
    (s_q.st == trwu_pkg::TRWU_ST_IDLE))
    else $error("execute cycle length wrong");
  a_hold_addr_sel: assert property (@(posedge i_clk) disable iff (i_reset)
    hold_we |-> (s_q.is_wr && (acc_ptr[`TRWU_HOLD_IDX_W-1:0] == ((s_q.mode == trwu_pkg::TRWU_MODE_PRE_INC)
    ? s_q.ptr[`TRWU_HOLD_IDX_W-1:0] + 6'h01 : s_q.ptr[`TRWU_HOLD_IDX_W-1:0]))))
    else $error("holding write misdirected");
  a_none_keeps_ptr: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_q.st == trwu_pkg::TRWU_ST_EXEC && i_phase == `TRWU_PH_Q4 && s_q.mode == trwu_pkg::TRWU_MODE_NONE)
    |=> (s_q.ptr == $past(s_q.ptr)))
    else $error("pointer moved in no change mode");
  a_pre_inc_ptr: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_q.st == trwu_pkg::TRWU_ST_EXEC && i_phase == `TRWU_PH_Q4 && s_q.mode == trwu_pkg::TRWU_MODE_PRE_INC)
    |=> (s_q.ptr == $past(s_q.ptr) + one_ptr))
    else $error("pre increment pointer wrong");
  a_idle_no_access: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_q.st != trwu_pkg::TRWU_ST_EXEC) |-> (!o_pmem_rd && !hold_we))
    else $error("access outside execute cycle");
  a_wr_keeps_lat: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_q.st == trwu_pkg::TRWU_ST_EXEC && s_q.is_wr) |=> $stable(s_q.lat))
    else $error("write changed latch");
  a_decode_opcode: assert property (@(posedge i_clk) disable iff (i_reset)
    o_table_op |-> (i_opcode[15:3] == 13'h0001))
    else $error("decode on foreign opcode");

  // main scenario covers
  c_read_done: cover property (@(posedge i_clk) o_pmem_rd);
  c_pre_inc_read: cover property (@(posedge i_clk) o_pmem_rd && s_q.mode == trwu_pkg::TRWU_MODE_PRE_INC);
  c_post_dec_write: cover property (@(posedge i_clk) hold_we && s_q.mode == trwu_pkg::TRWU_MODE_POST_DEC);
  c_write_done: cover property (@(posedge i_clk) hold_we);
  c_ptr_wrap: cover property (@(posedge i_clk) hold_we && s_q.ptr == {`TRWU_PTR_W{1'b1}});
endmodule : trwu_unit
`default_nettype wire

// [verif/table_read_write_unit_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module table_read_write_unit_tb;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [1:0]  i_phase = 2'h0;
  logic        i_op_valid = 1'b0;
  logic [15:0] i_opcode = 16'h0000;
  logic        i_ptr_load = 1'b0;
  logic [20:0] i_ptr_data = 21'h000000;
  logic        i_lat_load = 1'b0;
  logic [7:0]  i_lat_data = 8'h00;
  logic [5:0]  i_hold_raddr = 6'h00;
  logic [15:0] pm_word, op, w;
  logic [7:0]  hold_rdata, lat, e_lat;
  logic [20:0] pm_addr, ptr, e_ptr, a;
  logic        pm_rd, busy, hold_we, table_op, valid;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n_rd = 0;
  int          n_we = 0;
  int          nr0 = 0;
  int          nw0 = 0;
  logic [20:0] acc_addr = 21'h000000;
  //////////////////////////////////////////////////////////////////////////////
  // clock, free-running phase, watchdog
  always #2.5 i_clk = ~i_clk;
  always @(negedge i_clk) i_phase <= i_phase + 2'h1;
  always @(posedge i_clk)
  begin
    cycles++;
    // count memory reads and holding writes, keep the last access address
    if (pm_rd === 1'b1) n_rd++;
    if (hold_we === 1'b1) n_we++;
    if (pm_rd === 1'b1 || hold_we === 1'b1) acc_addr = pm_addr;
    if (cycles == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end
  trwu_unit uut (.i_clk(i_clk), .i_reset(i_reset), .i_phase(i_phase), .i_op_valid(i_op_valid),
    .i_opcode(i_opcode), .i_ptr_load(i_ptr_load), .i_ptr_data(i_ptr_data), .i_lat_load(i_lat_load),
    .i_lat_data(i_lat_data), .i_pmem_word(pm_word), .i_hold_raddr(i_hold_raddr),
    .o_hold_rdata(hold_rdata), .o_pmem_addr(pm_addr), .o_pmem_rd(pm_rd),
    .o_table_byte_pointer(ptr), .o_table_data_latch(lat), .o_busy(busy), .o_hold_we(hold_we),
    .o_table_op(table_op));
  trwu_pmem_model pmem (.i_clk(i_clk), .i_addr(pm_addr), .i_rd(pm_rd), .o_word(pm_word));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [20:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // issue one opcode at the next Q1, then let it finish
  task automatic do_op(input logic [15:0] o, input logic v);
    @(posedge i_clk);
    while (i_phase !== 2'h3) @(posedge i_clk);
    @(negedge i_clk);
    i_op_valid = 1'b1;
    i_opcode = o;
    @(posedge i_clk);
    check("table op", {20'h0, v}, {20'h0, table_op});
    @(negedge i_clk);
    i_op_valid = 1'b0;
    @(negedge i_clk);
    check("busy", {20'h0, v}, {20'h0, busy});
    repeat (8) @(negedge i_clk);
    check("busy end", 21'h0, {20'h0, busy});
  endtask : do_op
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  //////////////////////////////////////////////////////////////////////////////
  // main sequence: load, execute, compare with the reference
  initial
  begin
    void'($urandom(32'h43C20E77));
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_reset = 1'b0;
    check("pointer rst", 21'h0, ptr);
    check("latch rst", 21'h0, {13'h0, lat});
    check("busy rst", 21'h0, {20'h0, busy});
    for (int k = 0; k < 48; k++)
    begin
      @(negedge i_clk);
      i_ptr_load = 1'b1;
      i_lat_load = 1'b1;
      i_ptr_data = (k % 6 == 5) ? 21'h1FFFFF : (k % 6 == 4) ? 21'h000000 : 21'($urandom);
      i_lat_data = 8'($urandom);
      e_ptr = i_ptr_data;
      e_lat = i_lat_data;
      @(negedge i_clk);
      i_ptr_load = 1'b0;
      i_lat_load = 1'b0;
      op = (k % 5 == 4) ? (16'($urandom) | 16'h0010) : 16'(k % 8 + 8);
      valid = (op[15:4] == 12'h000) && op[3];
      a = (op[1:0] == 2'h3) ? e_ptr + 21'h1 : e_ptr;
      nr0 = n_rd;
      nw0 = n_we;
      do_op(op, valid);
      check("reads", {20'h0, valid && !op[2]}, 21'(n_rd - nr0));
      check("holding writes", {20'h0, valid && op[2]}, 21'(n_we - nw0));
      if (valid) check("access addr", a, acc_addr);
      if (valid)
      begin
        w = {a[8:1] ^ 8'h5A, a[16:9] + a[8:1]};
        if (!op[2]) e_lat = a[0] ? w[15:8] : w[7:0];
        if (op[1:0] == 2'h1 || op[1:0] == 2'h3) e_ptr = e_ptr + 21'h1;
        if (op[1:0] == 2'h2) e_ptr = e_ptr - 21'h1;
      end
      check("pointer", e_ptr, ptr);
      check("latch", {13'h0, e_lat}, {13'h0, lat});
      if (valid && op[2])
      begin
        i_hold_raddr = a[5:0];
        repeat (2) @(negedge i_clk);
        check("holding", {13'h0, e_lat}, {13'h0, hold_rdata});
      end
    end
    finish_test();
  end
endmodule : table_read_write_unit_tb
`default_nettype wire

// [verif/trwu_pmem_model.sv]
`timescale 1ns/10ps
`default_nettype none
module trwu_pmem_model
(
  input  wire logic        i_clk,
  input  wire logic [20:0] i_addr,
  input  wire logic        i_rd,
  output logic      [15:0] o_word
);
  logic [15:0] junk_q = 16'hA5C3;
  // junk flips each cycle so a stale word never looks valid
  always @(posedge i_clk) junk_q <= ~junk_q;
  // word content derived from the word address
  assign o_word = i_rd ? {i_addr[8:1] ^ 8'h5A, i_addr[16:9] + i_addr[8:1]} : junk_q;
endmodule : trwu_pmem_model
`default_nettype wire
